//--- dpw_pkg.sv
// Package for the dual PWM generator: register map, reset values, carriers.
// Assumes an APB master with 32-bit data and byte addressing.
package dpw_pkg;
  // Register word indices
  localparam logic [7:0] DPW_OFF_DUTY0 = 8'hfc;
  localparam logic [7:0] DPW_OFF_DUTY1 = 8'hfd;
  localparam logic [7:0] DPW_OFF_PRESCALE = 8'hfe;
  // Offsets are not all word aligned, so each is an index; byte address is index times four
  localparam int DPW_ADDR_W = 10;
  localparam logic [9:0] DPW_ADDR_DUTY0 = {DPW_OFF_DUTY0, 2'b00};
  localparam logic [9:0] DPW_ADDR_DUTY1 = {DPW_OFF_DUTY1, 2'b00};
  localparam logic [9:0] DPW_ADDR_PRESCALE = {DPW_OFF_PRESCALE, 2'b00};
  // Reset values
  localparam logic [7:0] DPW_RST_DUTY = 8'h00;
  localparam logic [7:0] DPW_RST_PRESCALE = 8'h00;
  // Counter wraps after this value
  localparam logic [7:0] DPW_CNT_LAST = 8'hfe;
  // Fixed divide by two ahead of the prescaler
  localparam int DPW_PRE_DIV = 2;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } dpw_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dpw_apb_rsp_t;
endpackage

//--- dpw_top.sv
// Dual PWM generator with APB register access.
// Assumes a single 100 MHz clock standing in for the oscillator; APB synchronous to it.
//
// Local design decision: register access over APB.
module dpw_top #(
  parameter int CHANNELS = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire dpw_pkg::dpw_apb_req_t apb_req,
  output dpw_pkg::dpw_apb_rsp_t apb_rsp,
  // Channel outputs
  output logic [CHANNELS-1:0] pwm_channel_output
);

  // Register map only has room for two compare registers
  if (CHANNELS != 2) begin : gen_bad_channels
    $error("dpw_top supports exactly two channels");
  end

  logic [7:0] duty_r [CHANNELS];
  logic [7:0] duty_nxt [CHANNELS];
  logic [7:0] reload_r;
  logic [7:0] reload_nxt;
  dpw_pkg::dpw_apb_rsp_t rsp_r;
  dpw_pkg::dpw_apb_rsp_t rsp_nxt;
  logic half_r;
  logic half_nxt;
  logic [7:0] pre_r;
  logic [7:0] pre_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [CHANNELS-1:0] out_r;
  logic [CHANNELS-1:0] out_nxt;
  logic access;
  logic [9:0] word_addr;
  logic addr_hi_zero;

  assign access = apb_req.psel && apb_req.penable;
  assign word_addr = apb_req.paddr[9:0];
  assign addr_hi_zero = (apb_req.paddr[31:10] == 22'h000000);

  // Register file; zero-wait APB, unmapped addresses answer with pslverr
  always_comb begin
    reload_nxt = reload_r;
    for (int i = 0; i < CHANNELS; i++) begin
      duty_nxt[i] = duty_r[i];
    end
    rsp_nxt.pready = 1'b0;
    rsp_nxt.pslverr = 1'b0;
    rsp_nxt.prdata = 32'h00000000;
    if (apb_req.psel && !apb_req.penable) begin
      rsp_nxt.pready = 1'b1;
      if (!addr_hi_zero) begin
        rsp_nxt.pslverr = 1'b1;
      end else begin
        case (word_addr)
          dpw_pkg::DPW_ADDR_DUTY0: begin
            rsp_nxt.prdata = {24'h000000, duty_r[0]};
          end
          dpw_pkg::DPW_ADDR_DUTY1: begin
            rsp_nxt.prdata = {24'h000000, duty_r[1]};
          end
          dpw_pkg::DPW_ADDR_PRESCALE: begin
            rsp_nxt.prdata = {24'h000000, reload_r};
          end
          default: begin
            rsp_nxt.pslverr = 1'b1;
          end
        endcase
      end
      if (apb_req.pwrite) begin
        rsp_nxt.prdata = 32'h00000000;
      end
    end
    // Write takes effect at the access edge, data is held until then
    if (access && rsp_r.pready && apb_req.pwrite && addr_hi_zero) begin
      case (word_addr)
        dpw_pkg::DPW_ADDR_DUTY0: begin
          duty_nxt[0] = apb_req.pwdata[7:0];
        end
        dpw_pkg::DPW_ADDR_DUTY1: begin
          duty_nxt[1] = apb_req.pwdata[7:0];
        end
        dpw_pkg::DPW_ADDR_PRESCALE: begin
          reload_nxt = apb_req.pwdata[7:0];
        end
        default: begin
          reload_nxt = reload_r;
        end
      endcase
    end
  end

  // Timebase shared by both channels
  always_comb begin
    half_nxt = ~half_r;
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    if (half_r) begin
      if (pre_r == 8'h00) begin
        pre_nxt = reload_r;
        if (cnt_r == dpw_pkg::DPW_CNT_LAST) begin
          cnt_nxt = 8'h00;
        end else begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end else begin
        pre_nxt = pre_r - 8'h01;
      end
    end
  end

  // Compare uses next duty so a write shows on the output at the same edge that loads the register
  generate
    for (genvar g = 0; g < CHANNELS; g++) begin : gen_chan
      always_comb begin
        out_nxt[g] = (duty_nxt[g] > cnt_nxt) ? 1'b0 : 1'b1;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) begin
        duty_r[i] <= dpw_pkg::DPW_RST_DUTY;
      end
      reload_r <= dpw_pkg::DPW_RST_PRESCALE;
      rsp_r <= '0;
      half_r <= 1'b0;
      pre_r <= 8'h00;
      cnt_r <= 8'h00;
      out_r <= '1;
    end else begin
      duty_r <= duty_nxt;
      reload_r <= reload_nxt;
      rsp_r <= rsp_nxt;
      half_r <= half_nxt;
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign apb_rsp = rsp_r;
  assign pwm_channel_output = out_r;

endmodule

//--- dpw_load.sv
// Integrating load on both outputs, like a filter or motor driver.
// Assumes the block clock; clr empties the integrators.
module dpw_load (
  // Clock, clear, output levels and integrated high time
  input wire logic clk,
  input wire logic clr,
  input wire logic [1:0] drive,
  output logic [15:0] hi [2]
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) for (int i = 0; i < 2; i++) hi[i] <= clr ? 16'h0000 : hi[i] + 16'(drive[i]);
endmodule

//--- dpw_chk_sva.sv
// Port checker for the PWM block.
// Assumes one clock domain and registered APB answers.
module dpw_chk #(parameter int CHANNELS = 2) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus and outputs
  input wire dpw_pkg::dpw_apb_req_t apb_req,
  input wire dpw_pkg::dpw_apb_rsp_t apb_rsp,
  input wire logic [CHANNELS-1:0] pwm_channel_output
);
  wire logic ok = apb_req.paddr inside {32'h3f0, 32'h3f4, 32'h3f8};
  wire logic [9:0] k = apb_rsp.pready && apb_req.pwrite && ok ? {apb_req.paddr[3:2], apb_req.pwdata[7:0]} : 10'h3ff;
  wire logic [CHANNELS-1:0] o = pwm_channel_output;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ready_setup_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready) else $error("ready late");
  err_decode_a: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !ok) else $error("bad error");
  duty0_zero_a: assert property (k == 10'h000 |=> o[0]) else $error("ch0 low");
  duty0_full_a: assert property (k == 10'h0ff |=> !o[0]) else $error("ch0 high");
  duty1_zero_a: assert property (k == 10'h100 |=> o[1]) else $error("ch1 low");
  duty1_full_a: assert property (k == 10'h1ff |=> !o[1]) else $error("ch1 high");
  // Counter steps at most every second clock, so no two level changes in a row while no duty register is written
  step_space_a: assert property ($changed(o) && k[9] && $past(k[9]) |=> $stable(o)) else $error("fast step");
  cover property (k == 10'h100);
  cover property (apb_rsp.pslverr);
  cover property ($fell(o[0]));
endmodule
bind dpw_top dpw_chk #(.CHANNELS(CHANNELS)) chk (.clk(clk), .rst_n(rst_n), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .pwm_channel_output(pwm_channel_output));

//--- tb_dual_pwm_generator.sv
// Bench for the PWM block with an integrating load.
// Assumes the checker is bound to the design.
module tb_dual_pwm_generator;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, clr = 1'b0, er;
  logic [1:0] p;
  logic [15:0] hi [2];
  logic [31:0] rd;
  dpw_pkg::dpw_apb_req_t q = '0;
  dpw_pkg::dpw_apb_rsp_t s;
  int fail_count = 0, comparisons = 0, n;
  logic [7:0] rows [3][2] = '{'{8'hff, 8'h00}, '{8'h00, 8'hff}, '{8'h01, 8'hfe}};
  dpw_top dut (.clk(clk), .rst_n(rst_n), .apb_req(q), .apb_rsp(s), .pwm_channel_output(p));
  dpw_load ld (.clk(clk), .clr(clr), .drive(p), .hi(hi));
  task automatic wrap_up;
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) fail_count++;
    if (g !== e) $display("MISMATCH %0t %h %h", $time, g, e);
  endtask
  task automatic rw(input logic w, input logic [31:0] a, d);
    @(posedge clk) q <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk) q.penable <= 1'b1;
    for (n = 0; n < 9 && s.pready !== 1'b1; n++) @(posedge clk);
    {er, rd} = {s.pslverr, s.prdata};
    q <= '0;
    cmp(n < 9, 1);
    if (n == 9) wrap_up();
  endtask
  task automatic run(input int c, input logic [31:0] e0, e1);
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (c) @(posedge clk);
    #1;
    cmp({hi[0], hi[1]}, {e0[15:0], e1[15:0]});
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rw(0, 32'h3f8, 0);
    cmp(rd, 0);
    foreach (rows[i]) begin
      rw(1, 32'h3f0, rows[i][0]);
      rw(1, 32'h3f4, rows[i][1]);
      run(510, 2 * (255 - rows[i][0]), 2 * (255 - rows[i][1]));
    end
    rw(1, 32'h3f8, 32'h3);
    rw(0, 32'h3f8, 0);
    cmp(rd, 32'h3);
    run(2040, 8 * (255 - 8'h01), 8 * (255 - 8'hfe));
    rw(0, 32'h3fc, 0);
    cmp(er, 1);
    rw(1, 32'h3f0, 32'hff);
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) cmp(p, 2'b11);
    rst_n <= 1'b1;
    rw(0, 32'h3f0, 0);
    cmp(rd, 0);
    rw(0, 32'h3f8, 0);
    cmp(rd, 0);
    wrap_up();
  end
endmodule
